//--- hdl/osp_pkg.sv
// Package for the one-shot timer channel pair: register map, fields, modes and bus carrier.
package osp_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] OFS_CH0_MODE = 6'h00;
  localparam logic [5:0] OFS_CH3_MODE = 6'h04;
  localparam logic [5:0] OFS_CH0_CMP = 6'h08;
  localparam logic [5:0] OFS_CH3_CMP = 6'h0C;
  localparam logic [5:0] OFS_OUT_MODE = 6'h10;
  localparam logic [5:0] OFS_OUT_POL = 6'h14;
  localparam logic [5:0] OFS_OUT_VAL = 6'h18;
  localparam logic [5:0] OFS_OUT_EN = 6'h1C;
  localparam logic [5:0] OFS_START = 6'h20;
  localparam logic [5:0] OFS_RUN_STAT = 6'h24;
  localparam logic [5:0] OFS_IRQ_REQ = 6'h28;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h2C;
  localparam logic [5:0] OFS_PRESCALE = 6'h30;
  localparam logic [5:0] OFS_PORT_DIR = 6'h34;

  // Mode register field positions, then channel and interrupt request bit positions.
  localparam int OPCLK_HI = 15;
  localparam int OPCLK_LO = 14;
  localparam int CNT_SRC_BIT = 12;
  localparam int HALF_BIT = 11;
  localparam int TRIG_HI = 10;
  localparam int TRIG_LO = 8;
  localparam int EDGE_HI = 7;
  localparam int EDGE_LO = 6;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 1;
  localparam int START_BIT = 0;
  localparam int CH0 = 0;
  localparam int CH3 = 3;
  localparam int IRQ_CH0_BIT = 4;

  // Reset values.
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'hFFFF;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] IRQ_MASK_RST = 8'hFF;
  localparam logic [7:0] PORT_DIR_RST = 8'hFF;
  localparam logic [15:0] PRESCALE_RST = 16'h0000;
  localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;

  // Master delay adds this many count periods.
  localparam logic [16:0] MASTER_EXTRA = 17'h00002;

  typedef enum logic [2:0] {
    OSP_MD_INTERVAL = 3'b000,
    OSP_MD_CAPTURE = 3'b010,
    OSP_MD_EVENT = 3'b011,
    OSP_MD_ONECOUNT = 3'b100,
    OSP_MD_CAP_ONE = 3'b110
  } osp_mode_t;

  typedef enum logic [2:0] {
    OSP_TRG_SW = 3'b000,
    OSP_TRG_EDGE = 3'b001,
    OSP_TRG_BOTH = 3'b010,
    OSP_TRG_MASTER = 3'b100
  } osp_trig_t;

  // Channel state: idle, waiting for a trigger and counting.
  typedef enum logic [1:0] {
    OSP_ST_IDLE = 2'b00,
    OSP_ST_WAIT = 2'b01,
    OSP_ST_COUNT = 2'b11
  } osp_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } osp_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } osp_rsp_t;

endpackage

//--- hdl/osp_timer_pair.sv
// One-shot timer channel pair: master channel 0 delay, slave channel 3 pulse width.
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps

module osp_timer_pair #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire osp_pkg::osp_req_t avs_req,
  output osp_pkg::osp_rsp_t avs_rsp,
  // Timer pins
  input wire logic ch0_timer_input,
  input wire logic ch3_timer_input,
  output logic ch0_out_pin,
  output logic ch3_out_pin,
  output logic ch3_pin_oe,
  // Interrupts seen by the processor
  output logic ch0_irq_service,
  output logic ch0_expiry_irq,
  output logic ch3_expiry_irq
);
  import osp_pkg::*;

  logic [15:0] mode_r [2];
  logic [15:0] cmp_r [2];
  logic [15:0] output_mode_reg, output_polarity_reg, output_value_reg, output_enable_reg;
  logic [15:0] prescale_r;
  logic [7:0] irq_request_flags_lo, irq_mask_flags_lo, port3_direction;
  logic [1:0] running_r;
  logic [15:0] presc_cnt_r;
  logic [3:0] prescaled_tick;
  logic [2:0] pin_sync_r [2];
  logic [1:0] pin_lvl_r;
  logic [CNT_W-1:0] count_register [2];
  osp_state_t st_r [2];
  logic [1:0] expiry, start_irq, trig, cnt_tick, edge_rise, edge_fall;
  logic [1:0] start_wr;
  logic wr_hit, rd_ack;
  logic [31:0] rdata_r;

  // Prescaler: four enables at the mclk rate divided by two to the selected power.
  function automatic logic prescaler_tick(input logic [15:0] cnt, input logic [3:0] pw);
    prescaler_tick = (pw == 4'h0) ? 1'b1 : (cnt & ((16'h0001 << pw) - 16'h0001)) == ZERO16;
  endfunction

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      presc_cnt_r <= ZERO16;
    end else begin
      presc_cnt_r <= presc_cnt_r + 16'h0001;
    end
  end

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      prescaled_tick[k] = prescaler_tick(presc_cnt_r, prescale_r[4*k +: 4]);
    end
  end

  // Pin synchronisers: a change counts once the second and third stages agree.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_sync_r[0] <= 3'h0;
      pin_sync_r[1] <= 3'h0;
      pin_lvl_r <= 2'h0;
    end else begin
      pin_sync_r[0] <= {pin_sync_r[0][1:0], ch0_timer_input};
      pin_sync_r[1] <= {pin_sync_r[1][1:0], ch3_timer_input};
      for (int c = 0; c < 2; c++) begin
        if (pin_sync_r[c][1] == pin_sync_r[c][2]) begin
          pin_lvl_r[c] <= pin_sync_r[c][2];
        end
      end
    end
  end

  // Selected operation clock with the documented crossed encoding.
  function automatic logic op_tick(input logic [1:0] sel, input logic [3:0] t);
    case (sel)
      2'b00: op_tick = t[0];
      2'b01: op_tick = t[2];
      2'b10: op_tick = t[1];
      default: op_tick = t[3];
    endcase
  endfunction

  // Valid edge by the edge-select field: 00 fall, 01 rise, else both.
  function automatic logic valid_edge(input logic [1:0] es, input logic r, input logic f);
    case (es)
      2'b00: valid_edge = f;
      2'b01: valid_edge = r;
      default: valid_edge = r | f;
    endcase
  endfunction

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      edge_rise[c] = pin_sync_r[c][2] & ~pin_lvl_r[c] & (pin_sync_r[c][1] == pin_sync_r[c][2]);
      edge_fall[c] = ~pin_sync_r[c][2] & pin_lvl_r[c] & (pin_sync_r[c][1] == pin_sync_r[c][2]);
      cnt_tick[c] = mode_r[c][CNT_SRC_BIT]
          ? valid_edge(mode_r[c][EDGE_HI:EDGE_LO], edge_rise[c], edge_fall[c])
          : op_tick(mode_r[c][OPCLK_HI:OPCLK_LO], prescaled_tick);
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      case (osp_trig_t'(mode_r[c][TRIG_HI:TRIG_LO]))
        OSP_TRG_EDGE: trig[c] = valid_edge(mode_r[c][EDGE_HI:EDGE_LO], edge_rise[c], edge_fall[c]);
        OSP_TRG_BOTH: trig[c] = edge_rise[c] | edge_fall[c];
        OSP_TRG_MASTER: trig[c] = (c == 1) ? expiry[0] | start_irq[0] : 1'b0;
        default: trig[c] = 1'b0;
      endcase
    end
  end

  // Bus decode shared by the register processes.
  assign wr_hit = avs_req.write;
  assign start_wr[0] = wr_hit && avs_req.address == OFS_START && avs_req.writedata[CH0];
  assign start_wr[1] = wr_hit && avs_req.address == OFS_START && avs_req.writedata[CH3];

  // Counter state machine per channel; index 0 is channel 0, index 1 is channel 3.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int c = 0; c < 2; c++) begin
        st_r[c] <= OSP_ST_IDLE;
        count_register[c] <= '0;
      end
      expiry <= 2'b00;
      start_irq <= 2'b00;
    end else begin
      expiry <= 2'b00;
      start_irq <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        logic [2:0] md;
        logic sb, upc, half, slv, strig, short_pulse;
        logic [CNT_W-1:0] ld, lim, cmp_m;
        md = mode_r[c][MODE_HI:MODE_LO];
        sb = mode_r[c][START_BIT];
        // Capture modes count up; event counting counts down like the others.
        upc = md[1] & ~md[0];
        // split narrows channel 3 to eight bits
        half = (c == 1) && mode_r[c][HALF_BIT];
        lim = half ? CNT_W'(8'hFF) : '1;
        cmp_m = CNT_W'(cmp_r[c]) & lim;
        // The slave sees the registered master interrupt a clock late, so it loads two short.
        slv = (c == 1) && osp_trig_t'(mode_r[c][TRIG_HI:TRIG_LO]) == OSP_TRG_MASTER;
        strig = trig[c] ||
                (osp_trig_t'(mode_r[c][TRIG_HI:TRIG_LO]) == OSP_TRG_SW && start_wr[c]);
        // Slave values below two cannot absorb that delay and give a one-clock pulse.
        short_pulse = slv && cmp_m < CNT_W'(2);
        // master counts value plus two periods, slave exactly its value
        ld = (c == 0) ? cmp_m + CNT_W'(MASTER_EXTRA) - CNT_W'(1)
                      : (slv ? cmp_m - CNT_W'(2) : cmp_m - CNT_W'(1));
        if (!running_r[c]) begin
          st_r[c] <= OSP_ST_IDLE;
        end else begin
          case (st_r[c])
            OSP_ST_IDLE: begin
              // running flag lets the mode decide when counting starts
              if (osp_mode_t'(md) == OSP_MD_ONECOUNT || osp_mode_t'(md) == OSP_MD_CAP_ONE) begin
                // One-count modes arm here and wait for their own start trigger.
                st_r[c] <= OSP_ST_WAIT;
              end else begin
                st_r[c] <= OSP_ST_COUNT;
                count_register[c] <= upc ? '0 : ld;
                start_irq[c] <= sb && (osp_mode_t'(md) == OSP_MD_INTERVAL ||
                                      osp_mode_t'(md) == OSP_MD_CAPTURE);
              end
            end
            OSP_ST_WAIT: begin
              if (strig && short_pulse) begin
                expiry[c] <= 1'b1;
              end else if (strig) begin
                st_r[c] <= OSP_ST_COUNT;
                count_register[c] <= upc ? '0 : ld;
              end
            end
            OSP_ST_COUNT: begin
              // one-count retrigger only with the start bit set
              if (osp_mode_t'(md) == OSP_MD_ONECOUNT && sb && strig) begin
                count_register[c] <= ld;
                start_irq[c] <= 1'b1;
              end else if (osp_mode_t'(md) == OSP_MD_CAP_ONE && trig[c]) begin
                // end of measured level captures and stops
                expiry[c] <= 1'b1;
                st_r[c] <= OSP_ST_WAIT;
              end else if (cnt_tick[c]) begin
                if (upc) begin
                  count_register[c] <= (count_register[c] & lim) + CNT_W'(1);
                end else if ((count_register[c] & lim) == '0) begin
                  // expiry pulse, then reload or wait
                  expiry[c] <= 1'b1;
                  if (osp_mode_t'(md) == OSP_MD_ONECOUNT) begin
                    st_r[c] <= OSP_ST_WAIT;
                  end else begin
                    count_register[c] <= ld;
                  end
                end else begin
                  count_register[c] <= count_register[c] - CNT_W'(1);
                end
              end
              if (osp_mode_t'(md) == OSP_MD_CAPTURE && trig[c]) begin
                expiry[c] <= 1'b1;
                count_register[c] <= '0;
              end
            end
            default: st_r[c] <= OSP_ST_IDLE;
          endcase
        end
      end
    end
  end

  assign ch0_expiry_irq = expiry[0] | start_irq[0];
  assign ch3_expiry_irq = expiry[1] | start_irq[1];

  // Configuration registers.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_r[0] <= MODE_RST;
      mode_r[1] <= MODE_RST;
      cmp_r[0] <= CMP_RST;
      cmp_r[1] <= CMP_RST;
      output_mode_reg <= ZERO16;
      output_polarity_reg <= ZERO16;
      output_enable_reg <= ZERO16;
      prescale_r <= PRESCALE_RST;
      irq_mask_flags_lo <= IRQ_MASK_RST;
      port3_direction <= PORT_DIR_RST;
    end else if (wr_hit) begin
      case (avs_req.address)
        OFS_CH0_MODE: mode_r[0] <= avs_req.writedata[15:0];
        OFS_CH3_MODE: mode_r[1] <= avs_req.writedata[15:0];
        OFS_CH0_CMP: cmp_r[0] <= avs_req.writedata[15:0];
        OFS_CH3_CMP: cmp_r[1] <= avs_req.writedata[15:0];
        OFS_OUT_MODE: output_mode_reg <= avs_req.writedata[15:0] & 16'h000E;
        OFS_OUT_POL: output_polarity_reg <= avs_req.writedata[15:0] & 16'h000E;
        OFS_OUT_EN: output_enable_reg <= avs_req.writedata[15:0] & 16'h000F;
        OFS_PRESCALE: prescale_r <= avs_req.writedata[15:0];
        OFS_IRQ_MASK: irq_mask_flags_lo <= avs_req.writedata[7:0];
        OFS_PORT_DIR: port3_direction <= avs_req.writedata[7:0];
        default: ;
      endcase
    end
  end

  // running flags set by start bits only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      running_r <= 2'b00;
    end else begin
      running_r <= running_r | start_wr;
    end
  end

  // request flag: hardware set wins over software clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_request_flags_lo <= 8'h00;
    end else begin
      if (wr_hit && avs_req.address == OFS_IRQ_REQ) begin
        irq_request_flags_lo <= avs_req.writedata[7:0];
      end
      if (ch0_expiry_irq) begin
        irq_request_flags_lo[IRQ_CH0_BIT] <= 1'b1;
      end
    end
  end

  assign ch0_irq_service = irq_request_flags_lo[IRQ_CH0_BIT] & ~irq_mask_flags_lo[IRQ_CH0_BIT];

  // Output value bits for channels 0 and 3.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      output_value_reg <= ZERO16;
    end else begin
      for (int b = 0; b < 4; b++) begin
        // software owns the bit only while output is disabled
        if (!output_enable_reg[b]) begin
          if (wr_hit && avs_req.address == OFS_OUT_VAL) begin
            // one bit per channel, upper bits zero
            output_value_reg[b] <= avs_req.writedata[b];
          end
        end else if (b == CH0) begin
          if (ch0_expiry_irq) begin
            output_value_reg[b] <= ~output_value_reg[b];
          end
        end else if (b == CH3) begin
          // toggle on own interrupt or set by master, clear by slave
          if (!output_mode_reg[CH3]) begin
            if (ch3_expiry_irq) begin
              output_value_reg[b] <= ~output_value_reg[b];
            end
          end else if (ch3_expiry_irq) begin
            output_value_reg[b] <= 1'b0;
          end else if (ch0_expiry_irq) begin
            output_value_reg[b] <= 1'b1;
          end
        end
      end
    end
  end

  // pins driven from registered level, channel 3 after polarity, channel 0 without
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ch0_out_pin <= 1'b0;
      ch3_out_pin <= 1'b0;
      ch3_pin_oe <= 1'b0;
    end else begin
      ch0_out_pin <= output_value_reg[CH0];
      ch3_out_pin <= output_value_reg[CH3] ^ output_polarity_reg[CH3];
      ch3_pin_oe <= ~port3_direction[1];
    end
  end

  // Read path: one wait cycle, then data with waitrequest low.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_ack <= 1'b0;
      rdata_r <= BUS_ERR_DATA;
    end else begin
      rd_ack <= avs_req.read & ~rd_ack;
      case (avs_req.address)
        OFS_CH0_MODE: rdata_r <= {16'h0000, mode_r[0]};
        OFS_CH3_MODE: rdata_r <= {16'h0000, mode_r[1]};
        OFS_CH0_CMP: rdata_r <= {16'h0000, cmp_r[0]};
        OFS_CH3_CMP: rdata_r <= {16'h0000, cmp_r[1]};
        OFS_OUT_MODE: rdata_r <= {16'h0000, output_mode_reg};
        OFS_OUT_POL: rdata_r <= {16'h0000, output_polarity_reg};
        OFS_OUT_VAL: rdata_r <= {16'h0000, output_value_reg};
        OFS_OUT_EN: rdata_r <= {16'h0000, output_enable_reg};
        OFS_RUN_STAT: rdata_r <= {28'h0000000, running_r[1], 2'b00, running_r[0]};
        OFS_IRQ_REQ: rdata_r <= {24'h000000, irq_request_flags_lo};
        OFS_IRQ_MASK: rdata_r <= {24'h000000, irq_mask_flags_lo};
        OFS_PRESCALE: rdata_r <= {16'h0000, prescale_r};
        OFS_PORT_DIR: rdata_r <= {24'h000000, port3_direction};
        default: rdata_r <= BUS_ERR_DATA;
      endcase
    end
  end

  assign avs_rsp.waitrequest = avs_req.read & ~rd_ack;
  assign avs_rsp.readdata = rdata_r;

endmodule // osp_timer_pair

//--- verification/osp_timer_pair_props.sv
// Concurrent checks on the ports of the one-shot timer channel pair.
`timescale 1ns/1ps
module osp_timer_pair_props #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire osp_pkg::osp_req_t avs_req,
  input wire osp_pkg::osp_rsp_t avs_rsp,
  // Pin and interrupts
  input wire logic ch3_out_pin,
  input wire logic ch0_irq_service,
  input wire logic ch0_expiry_irq,
  input wire logic ch3_expiry_irq
);
  import osp_pkg::*;
  logic wr_take;
  logic slave_on;
  logic msk4_s;
  logic [3:0] om_s;
  logic [3:0] pol_s;
  logic [3:0] en_s;
  logic [3:0] val_s;
  logic [15:0] cmp3_s;
  logic [15:0] md3_s;
  logic [16:0] since0;

  assign wr_take = avs_req.write && !avs_rsp.waitrequest;
  assign slave_on = om_s[3] && en_s[3] && (md3_s == 16'h0408);

  // Shadow of the registers that the pin and service checks depend on, taken from the bus itself.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmp3_s <= CMP_RST;
      md3_s <= MODE_RST;
      om_s <= 4'h0;
      pol_s <= 4'h0;
      en_s <= 4'h0;
      val_s <= 4'h0;
      msk4_s <= IRQ_MASK_RST[IRQ_CH0_BIT];
    end else if (wr_take) begin
      case (avs_req.address)
        OFS_CH3_CMP: cmp3_s <= avs_req.writedata[15:0];
        OFS_CH3_MODE: md3_s <= avs_req.writedata[15:0];
        OFS_OUT_MODE: om_s <= avs_req.writedata[3:0];
        OFS_OUT_POL: pol_s <= avs_req.writedata[3:0];
        OFS_OUT_EN: en_s <= avs_req.writedata[3:0];
        OFS_OUT_VAL: val_s <= avs_req.writedata[3:0];
        OFS_IRQ_MASK: msk4_s <= avs_req.writedata[IRQ_CH0_BIT];
        default: ;
      endcase
    end
  end

  // Cycles since the master expired; it saturates so a stray slave expiry cannot match.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      since0 <= 17'h1FFFF;
    end else if (ch0_expiry_irq) begin
      since0 <= 17'h00001;
    end else if (since0 != 17'h1FFFF) begin
      since0 <= since0 + 17'h00001;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  chk_irq0_pulse:
  assert property (ch0_expiry_irq |=> !ch0_expiry_irq)
    else $error("channel 0 expiry lasts more than one clock");
  chk_irq3_pulse:
  assert property ($rose(ch3_expiry_irq) |-> ##1 $fell(ch3_expiry_irq))
    else $error("channel 3 expiry lasts more than one clock");
  chk_slave_width:
  assert property (ch3_expiry_irq && slave_on |-> since0 == {1'h0, cmp3_s})
    else $error("slave expiry not compare value cycles after master");
  chk_slave_set:
  assert property (ch0_expiry_irq && slave_on && cmp3_s > 16'h0004
    |-> ##[1:3] ch3_out_pin != pol_s[3])
    else $error("master expiry did not set the pulse");
  chk_slave_clear:
  assert property (ch3_expiry_irq && slave_on |-> ##[1:3] ch3_out_pin == pol_s[3])
    else $error("slave expiry did not clear the pulse");
  chk_sw_level:
  assert property (wr_take && avs_req.address == OFS_OUT_VAL && !en_s[3]
    |-> ##[1:3] ch3_out_pin == (val_s[3] ^ pol_s[3]))
    else $error("software output level not on the pin");
  chk_mask_block:
  assert property (msk4_s |-> !ch0_irq_service)
    else $error("masked request still serviced");
  chk_flag_service:
  assert property (ch0_expiry_irq && !msk4_s |-> ##[1:2] ch0_irq_service)
    else $error("unmasked expiry not serviced");
endmodule // osp_timer_pair_props

bind osp_timer_pair osp_timer_pair_props #(.CNT_W(CNT_W)) i_osp_timer_pair_props (
  .mclk(mclk), .sys_rst(sys_rst), .avs_req(avs_req), .avs_rsp(avs_rsp),
  .ch3_out_pin(ch3_out_pin), .ch0_irq_service(ch0_irq_service),
  .ch0_expiry_irq(ch0_expiry_irq), .ch3_expiry_irq(ch3_expiry_irq));

//--- verification/osp_pin_sink.sv
// Receiver on the channel 3 pulse pin: measures the length of each active pulse.
`timescale 1ns/1ps
module osp_pin_sink (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Pin as seen from outside
  input wire logic pin,
  input wire logic oe,
  input wire logic act_low,
  // Measurements
  output int width_last,
  output int pulses
);
  int run;
  logic wire_lvl;
  // pin level on the wire, before the active-low sense is applied
  // An undriven pin floats to its pull-up, so a released buffer never looks like a driven low.
  assign wire_lvl = oe ? pin : 1'h1;
  always @(posedge mclk) begin
    if (sys_rst) begin
      run <= 0;
      width_last <= 0;
      pulses <= 0;
    end else if ((wire_lvl ^ act_low) === 1'h1) begin
      run <= run + 1;
    end else if (run != 0) begin
      width_last <= run;
      pulses <= pulses + 1;
      run <= 0;
    end
  end
endmodule // osp_pin_sink

//--- verification/tb_top.sv
// Self-checking bench for the one-shot timer channel pair.
`timescale 1ns/1ps
module tb_top;
  import osp_pkg::*;
  logic mclk;
  logic sys_rst;
  logic ch0_ti;
  logic ch3_ti;
  logic act_low;
  osp_req_t avs_req;
  osp_rsp_t avs_rsp;
  logic ch0_out_pin, ch3_out_pin, ch3_pin_oe, ch0_irq_service, ch0_expiry_irq, ch3_expiry_irq;
  logic [31:0] rd;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_irq0 = 0;
  int t_irq3 = 0;
  int tw, t, cmp0, cmp3, width_last, pulses, p0;
  int mdl [int];

  osp_timer_pair #(.CNT_W(16)) i_osp_timer_pair (
    .mclk(mclk), .sys_rst(sys_rst), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .ch0_timer_input(ch0_ti), .ch3_timer_input(ch3_ti), .ch0_out_pin(ch0_out_pin),
    .ch3_out_pin(ch3_out_pin), .ch3_pin_oe(ch3_pin_oe), .ch0_irq_service(ch0_irq_service),
    .ch0_expiry_irq(ch0_expiry_irq), .ch3_expiry_irq(ch3_expiry_irq));
  osp_pin_sink i_osp_pin_sink (.mclk(mclk), .sys_rst(sys_rst), .pin(ch3_out_pin),
    .oe(ch3_pin_oe), .act_low(act_low), .width_last(width_last), .pulses(pulses));

  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  // Timer inputs toggle at random; with clock counting and software or master triggers they must not matter.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    ch0_ti <= 1'($urandom_range(1, 0));
    ch3_ti <= 1'($urandom_range(1, 0));
    // An interrupt seen at this edge was launched at the previous one.
    if (ch0_expiry_irq === 1'h1) begin
      t_irq0 <= cyc - 1;
      mdl[OFS_IRQ_REQ] = mdl[OFS_IRQ_REQ] | 32'h10;
    end
    if (ch3_expiry_irq === 1'h1) t_irq3 <= cyc - 1;
  end

  task automatic close_out();
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_req.write <= wr;
    avs_req.read <= !wr;
    avs_req.address <= a;
    avs_req.writedata <= d;
    @(posedge mclk);
    while (avs_rsp.waitrequest !== 1'h0) begin
      n++;
      if (n > 20) begin
        fail_count++;
        $display("unexpected at %0t: bus answer missing", $time);
        close_out();
      end
      @(posedge mclk);
    end
    rd = avs_rsp.readdata;
    tw = cyc;
    avs_req.write <= 1'h0;
    avs_req.read <= 1'h0;
    @(posedge mclk);
  endtask

  // Writes also update the model: enabled output bits keep their value, start bits only set.
  task automatic wr(input logic [5:0] a, input int d);
    bus(1'h1, a, d);
    if (a == OFS_OUT_VAL)
      mdl[a] = (d & 32'hF & ~mdl[OFS_OUT_EN]) | (mdl[a] & mdl[OFS_OUT_EN]);
    else if (a == OFS_START)
      mdl[OFS_RUN_STAT] = mdl[OFS_RUN_STAT] | (d & 32'h9);
    else if (mdl.exists(a) && a != OFS_RUN_STAT)
      mdl[a] = d;
  endtask

  task automatic rc(input logic [5:0] a);
    bus(1'h0, a, 32'h0);
    check(rd, mdl.exists(a) ? mdl[a] : 0);
  endtask

  task automatic readall();
    for (int a = 0; a <= 32'h3C; a += 4) begin
      if (a != 32'h20) rc(6'(a));
    end
  endtask

  initial begin
    sys_rst = 1'h1;
    avs_req = '0;
    ch0_ti = 1'h0;
    ch3_ti = 1'h0;
    act_low = 1'h0;
    void'($urandom(79839));
    for (int a = 0; a <= 32'h34; a += 4) mdl[a] = 0;
    mdl.delete(32'h20);
    mdl[OFS_CH0_CMP] = CMP_RST;
    mdl[OFS_CH3_CMP] = CMP_RST;
    mdl[OFS_IRQ_MASK] = IRQ_MASK_RST;
    mdl[OFS_PORT_DIR] = PORT_DIR_RST;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'h0;
    readall();
    wr(OFS_OUT_VAL, 32'hFFFF);
    rc(OFS_OUT_VAL);
    check(ch0_out_pin, 1'h1);
    check(ch3_out_pin, 1'h1);
    act_low <= 1'h1;
    wr(OFS_OUT_POL, 32'h8);
    repeat (2) @(posedge mclk);
    check(ch3_out_pin, 1'h0);
    wr(OFS_OUT_VAL, 32'h0);
    wr(OFS_OUT_EN, 32'h8);
    wr(OFS_OUT_VAL, 32'h8);
    rc(OFS_OUT_VAL);
    wr(OFS_PORT_DIR, 32'hFD);
    // one-count master, slave on master interrupt, low mode bits kept 0
    wr(OFS_CH0_MODE, 32'h8);
    wr(OFS_CH3_MODE, 32'h408);
    wr(OFS_OUT_MODE, 32'h8);
    wr(OFS_IRQ_MASK, 32'hEF);
    wr(OFS_START, 32'h0);
    rc(OFS_RUN_STAT);
    wr(OFS_START, 32'h9);
    readall();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_OUT_POL, i[0] ? 32'h8 : 32'h0);
      // The pin changes sense at this edge too, so the sink sees no false pulse.
      act_low <= i[0];
      p0 = pulses;
      cmp0 = $urandom_range(40, 8);
      cmp3 = $urandom_range(30, 5);
      wr(OFS_CH0_CMP, cmp0);
      wr(OFS_CH3_CMP, cmp3);
      wr(OFS_START, 32'h1);
      t = tw;
      if (i == 2) wr(OFS_START, 32'h1);
      for (int n = 0; t_irq3 <= t; n++) begin
        if (n > 400) begin
          fail_count++;
          $display("unexpected at %0t: pulse never ended", $time);
          close_out();
        end
        @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
      check(t_irq0 - t, cmp0 + 2);
      check(t_irq3 - t_irq0, cmp3);
      check(width_last, cmp3);
      check(pulses - p0, 1);
      check(ch3_out_pin, i[0]);
    end
    check(ch0_irq_service, 1'h1);
    rc(OFS_IRQ_REQ);
    wr(OFS_IRQ_MASK, 32'hFF);
    check(ch0_irq_service, 1'h0);
    wr(OFS_IRQ_REQ, 32'h0);
    rc(OFS_IRQ_REQ);
    wr(OFS_IRQ_MASK, 32'hEF);
    check(ch0_irq_service, 1'h0);
    close_out();
  end
endmodule // tb_top
